// File: io_map_pkg.sv
// Shared constants for the fieldbus I/O register map link
`default_nettype none
package io_map_pkg;
    // ****************************************************************
    // Function codes
    // ****************************************************************
    localparam logic [7:0] FN_READ_COILS     = 8'h01;
    localparam logic [7:0] FN_READ_INPUTS    = 8'h02;
    localparam logic [7:0] FN_READ_HOLDING   = 8'h03;
    localparam logic [7:0] FN_READ_INPUT_REG = 8'h04;
    localparam logic [7:0] FN_WRITE_COIL     = 8'h05;
    localparam logic [7:0] FN_WRITE_REG      = 8'h06;
    localparam logic [7:0] FN_WRITE_COILS    = 8'h0f;
    localparam logic [7:0] FN_WRITE_REGS     = 8'h10;

    // ****************************************************************
    // Exception codes, zero means success
    // ****************************************************************
    localparam logic [7:0] EXC_NONE      = 8'h00;
    localparam logic [7:0] EXC_BAD_FUNC  = 8'h01;
    localparam logic [7:0] EXC_BAD_ADDR  = 8'h02;
    localparam logic [7:0] EXC_BAD_VALUE = 8'h03;

    // ****************************************************************
    // Coil force values for single coil writes
    // ****************************************************************
    localparam logic [15:0] COIL_ON  = 16'hff00;
    localparam logic [15:0] COIL_OFF = 16'h0000;

    // ****************************************************************
    // Resource counts
    // ****************************************************************
    localparam int N_COIL = 4;
    localparam int N_DI   = 4;
    localparam int N_AI   = 2;
    localparam int N_AO   = 2;

    // ****************************************************************
    // Zero-based register offsets
    // ****************************************************************
    localparam logic [15:0] IR_AI_BASE    = 16'h0004;
    localparam logic [15:0] REG_DI_WORD   = 16'h0030;
    localparam logic [15:0] HR_AO_BASE    = 16'h0800;
    localparam logic [15:0] HR_COIL_WORD  = 16'h0830;

    // ****************************************************************
    // Analog status word bits
    // ****************************************************************
    localparam int ST_UNDER_BIT = 0;
    localparam int ST_OVER_BIT  = 1;
    localparam int ST_ERROR_BIT = 6;

    // ****************************************************************
    // Coupler variants and their words per analog channel
    // ****************************************************************
    typedef enum logic [1:0] {
        VAR_STANDARD,
        VAR_SERIAL,
        VAR_ETHERNET
    } variant_t;

    localparam logic [15:0] STRIDE_STANDARD = 16'h0002;
    localparam logic [15:0] STRIDE_SERIAL   = 16'h0001;
    localparam logic [15:0] STRIDE_ETHERNET = 16'h0004;
endpackage
`default_nettype wire

// File: io_map_link_if.sv
// Request and answer link between the master end and the coupler map
`default_nettype none
interface io_map_link_if;
    logic        req_valid;
    logic [7:0]  req_func;
    logic [15:0] req_addr;
    logic [15:0] req_wdata;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic [7:0]  rsp_exc;

    modport coupler (
        input  req_valid, req_func, req_addr, req_wdata,
        output rsp_valid, rsp_data, rsp_exc
    );
    modport master (
        output req_valid, req_func, req_addr, req_wdata,
        input  rsp_valid, rsp_data, rsp_exc
    );
endinterface
`default_nettype wire

// File: io_map_coupler.sv
// Coupler end: maps discrete and analog points onto bit and word registers
//
// Contract
// - Coils read fn1, force fn5, fn15
// - Coils packed in holding word, fn3
// - Discrete inputs read per bit, fn2
// - Inputs packed word via fn4 and fn3
// - Analog channels reachable by words only
// - Analog input: status word plus data word
// - Analog output: control word then data
// - Control word writes change nothing
// - Unused upper status byte still takes address
// - Output data written with fn6 or fn16
// - Outputs contiguous from base, control/data alternating
// - Input status/data read by fn4, fn3
// - Status bits: 6 error, 1 over, 0 under
// - Master extracts status bits itself
// - Serial variant: one data word per channel
// - Ethernet variant: four words per channel
`default_nettype none
module io_map_coupler #(
    parameter io_map_pkg::variant_t VARIANT = io_map_pkg::VAR_STANDARD
) (
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_rst,
    input  wire logic                      i_ce,
    io_map_link_if.coupler                 link,
    input  wire logic [io_map_pkg::N_DI-1:0] i_di,
    input  wire logic [io_map_pkg::N_AI-1:0] i_ai_error,
    input  wire logic [io_map_pkg::N_AI-1:0] i_ai_over,
    input  wire logic [io_map_pkg::N_AI-1:0] i_ai_under,
    input  wire logic [io_map_pkg::N_AI*16-1:0] i_ai_value,
    output logic [io_map_pkg::N_COIL-1:0]  o_coil_state,
    output logic [io_map_pkg::N_AO*16-1:0] o_ao_value
);
    // ****************************************************************
    // Channel layout decode
    // ****************************************************************
    localparam logic [15:0] STRIDE = (VARIANT == io_map_pkg::VAR_SERIAL)
        ? io_map_pkg::STRIDE_SERIAL
        : (VARIANT == io_map_pkg::VAR_ETHERNET) ? io_map_pkg::STRIDE_ETHERNET
                                                : io_map_pkg::STRIDE_STANDARD;

    // Slot within channel: 0 status/control, 1 data, others padding; with the serial stride slot 0 is data
    function automatic logic [15:0] chan_of(input logic [15:0] off);
        return off / STRIDE;
    endfunction
    function automatic logic [15:0] slot_of(input logic [15:0] off);
        return off % STRIDE;
    endfunction
    function automatic logic is_data_slot(input logic [15:0] off);
        return (STRIDE == io_map_pkg::STRIDE_SERIAL) ? 1'b1 : (slot_of(off) == 16'h0001);
    endfunction

    logic [io_map_pkg::N_COIL-1:0]  coil_reg;
    logic [io_map_pkg::N_AO*16-1:0] ao_reg;
    logic                           rsp_valid_reg;
    logic [15:0]                    rsp_data_reg;
    logic [7:0]                     rsp_exc_reg;

    wire [7:0]  fn    = link.req_func;
    wire [15:0] addr  = link.req_addr;
    wire [15:0] wdata = link.req_wdata;

    wire [15:0] ai_off = addr - io_map_pkg::IR_AI_BASE;
    wire [15:0] ao_off = addr - io_map_pkg::HR_AO_BASE;
    wire        ai_hit = (addr >= io_map_pkg::IR_AI_BASE) &&
                         (ai_off < 16'(io_map_pkg::N_AI) * STRIDE);
    wire        ao_hit = (addr >= io_map_pkg::HR_AO_BASE) &&
                         (ao_off < 16'(io_map_pkg::N_AO) * STRIDE);
    wire [15:0] ai_ch  = chan_of(ai_off);
    wire [15:0] ao_ch  = chan_of(ao_off);
    wire        ai_dat = is_data_slot(ai_off);
    wire        ao_dat = is_data_slot(ao_off);
    wire [15:0] ai_slot = slot_of(ai_off);
    wire [15:0] ao_slot = slot_of(ao_off);

    // Status word keeps upper byte and unassigned bits at zero
    wire [15:0] ai_status = (16'(i_ai_error[ai_ch[0]]) << io_map_pkg::ST_ERROR_BIT) |
                            (16'(i_ai_over[ai_ch[0]])  << io_map_pkg::ST_OVER_BIT)  |
                            (16'(i_ai_under[ai_ch[0]]) << io_map_pkg::ST_UNDER_BIT);
    wire [15:0] ai_word = ai_dat ? i_ai_value[ai_ch[0]*16 +: 16]
                        : (ai_slot == 16'h0000) ? ai_status : 16'h0000;
    // Control word has no storage and reads zero
    wire [15:0] ao_word = ao_dat ? ao_reg[ao_ch[0]*16 +: 16] : 16'h0000;

    wire [15:0] di_word   = 16'(i_di);
    wire [15:0] coil_word = 16'(coil_reg);

    // ****************************************************************
    // Request decode
    // ****************************************************************
    wire coil_ok = addr < 16'(io_map_pkg::N_COIL);
    wire di_ok   = addr < 16'(io_map_pkg::N_DI);
    wire is_read_bits  = (fn == io_map_pkg::FN_READ_COILS) || (fn == io_map_pkg::FN_READ_INPUTS);
    wire is_write_coil = (fn == io_map_pkg::FN_WRITE_COIL) || (fn == io_map_pkg::FN_WRITE_COILS);
    wire is_write_reg  = (fn == io_map_pkg::FN_WRITE_REG)  || (fn == io_map_pkg::FN_WRITE_REGS);
    wire single_bad    = (fn == io_map_pkg::FN_WRITE_COIL) &&
                         (wdata != io_map_pkg::COIL_ON) && (wdata != io_map_pkg::COIL_OFF);
    wire coil_value    = (fn == io_map_pkg::FN_WRITE_COIL) ? (wdata == io_map_pkg::COIL_ON)
                                                           : wdata[0];

    logic [15:0] rd_data;
    logic [7:0]  exc;
    always_comb begin
        rd_data = 16'h0000;
        exc     = io_map_pkg::EXC_NONE;
        unique case (fn)
            io_map_pkg::FN_READ_COILS: begin
                if (coil_ok) rd_data = 16'(coil_reg[addr[1:0]]);
                else exc = io_map_pkg::EXC_BAD_ADDR;
            end
            io_map_pkg::FN_READ_INPUTS: begin
                if (di_ok) rd_data = 16'(i_di[addr[1:0]]);
                else exc = io_map_pkg::EXC_BAD_ADDR;
            end
            io_map_pkg::FN_READ_INPUT_REG: begin
                if (ai_hit) rd_data = ai_word;
                else if (addr == io_map_pkg::REG_DI_WORD) rd_data = di_word;
                else exc = io_map_pkg::EXC_BAD_ADDR;
            end
            io_map_pkg::FN_READ_HOLDING: begin
                if (ai_hit) rd_data = ai_word;
                else if (addr == io_map_pkg::REG_DI_WORD) rd_data = di_word;
                else if (addr == io_map_pkg::HR_COIL_WORD) rd_data = coil_word;
                else if (ao_hit) rd_data = ao_word;
                else exc = io_map_pkg::EXC_BAD_ADDR;
            end
            io_map_pkg::FN_WRITE_COIL, io_map_pkg::FN_WRITE_COILS: begin
                // Bit-level access never touches analog space
                if (!coil_ok) exc = io_map_pkg::EXC_BAD_ADDR;
                else if (single_bad) exc = io_map_pkg::EXC_BAD_VALUE;
            end
            io_map_pkg::FN_WRITE_REG, io_map_pkg::FN_WRITE_REGS: begin
                if (!ao_hit) exc = io_map_pkg::EXC_BAD_ADDR;
            end
            default: exc = io_map_pkg::EXC_BAD_FUNC;
        endcase
    end

    wire do_coil = link.req_valid && is_write_coil && (exc == io_map_pkg::EXC_NONE);
    // Control slot and padding accept the write but store nothing
    wire do_ao   = link.req_valid && is_write_reg && (exc == io_map_pkg::EXC_NONE)
                   && ao_dat;

    // ****************************************************************
    // State and answer
    // ****************************************************************
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            coil_reg      <= '0;
            ao_reg        <= '0;
            rsp_valid_reg <= 1'b0;
            rsp_data_reg  <= 16'h0000;
            rsp_exc_reg   <= 8'h00;
        end else if (i_ce) begin
            rsp_valid_reg <= link.req_valid;
            if (link.req_valid) begin
                rsp_data_reg <= (is_write_coil || is_write_reg) ? wdata : rd_data;
                rsp_exc_reg  <= exc;
            end
            if (do_coil) coil_reg[addr[1:0]] <= coil_value;
            if (do_ao) ao_reg[ao_ch[0]*16 +: 16] <= wdata;
        end
    end

    assign link.rsp_valid = rsp_valid_reg && i_ce;
    assign link.rsp_data  = rsp_data_reg;
    assign link.rsp_exc   = rsp_exc_reg;
    assign o_coil_state   = coil_reg;
    assign o_ao_value     = ao_reg;

    wire unused_ok = ^{ai_ch[15:1], ao_ch[15:1], ao_slot, is_read_bits};
endmodule // io_map_coupler
`default_nettype wire

// File: io_map_master.sv
// Master end: splits user commands into single-item link requests
`default_nettype none
module io_map_master (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    io_map_link_if.master    link,
    input  wire logic        i_cmd_valid,
    output logic             o_cmd_ready,
    input  wire logic [7:0]  i_cmd_func,
    input  wire logic [15:0] i_cmd_addr,
    input  wire logic [7:0]  i_cmd_count,
    input  wire logic        i_wdata_valid,
    output logic             o_wdata_ready,
    input  wire logic [15:0] i_wdata,
    output logic             o_rsp_valid,
    output logic             o_rsp_last,
    output logic [15:0]      o_rsp_data,
    output logic [7:0]       o_rsp_exc,
    output logic [2:0]       o_rsp_flags
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEND,
        ST_WAIT
    } state_t;

    function automatic logic is_write(input logic [7:0] f);
        return (f == io_map_pkg::FN_WRITE_COIL) || (f == io_map_pkg::FN_WRITE_REG) ||
               (f == io_map_pkg::FN_WRITE_COILS) || (f == io_map_pkg::FN_WRITE_REGS);
    endfunction

    state_t      state_reg;
    logic [7:0]  func_reg;
    logic [15:0] addr_reg;
    logic [7:0]  count_reg;
    logic        req_valid_reg;
    logic [15:0] req_wdata_reg;
    logic        rsp_valid_reg;
    logic        rsp_last_reg;
    logic [15:0] rsp_data_reg;
    logic [7:0]  rsp_exc_reg;

    // ****************************************************************
    // Handshakes
    // ****************************************************************
    wire single  = (i_cmd_func == io_map_pkg::FN_WRITE_COIL) ||
                   (i_cmd_func == io_map_pkg::FN_WRITE_REG) || (i_cmd_count == 8'h00);
    wire writing = is_write(func_reg);
    wire send_go = (state_reg == ST_SEND) && (!writing || i_wdata_valid);
    wire last    = (count_reg == 8'h01) || (link.rsp_exc != io_map_pkg::EXC_NONE);
    assign o_cmd_ready   = (state_reg == ST_IDLE) && i_ce;
    assign o_wdata_ready = (state_reg == ST_SEND) && writing && i_ce;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_reg     <= ST_IDLE;
            func_reg      <= 8'h00;
            addr_reg      <= 16'h0000;
            count_reg     <= 8'h00;
            req_valid_reg <= 1'b0;
            req_wdata_reg <= 16'h0000;
            rsp_valid_reg <= 1'b0;
            rsp_last_reg  <= 1'b0;
            rsp_data_reg  <= 16'h0000;
            rsp_exc_reg   <= 8'h00;
        end else if (i_ce) begin
            req_valid_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    if (i_cmd_valid) begin
                        func_reg  <= i_cmd_func;
                        addr_reg  <= i_cmd_addr;
                        count_reg <= single ? 8'h01 : i_cmd_count;
                        state_reg <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (send_go) begin
                        req_valid_reg <= 1'b1;
                        req_wdata_reg <= writing ? i_wdata : 16'h0000;
                        state_reg     <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (link.rsp_valid) begin
                        rsp_valid_reg <= 1'b1;
                        rsp_last_reg  <= last;
                        rsp_data_reg  <= link.rsp_data;
                        rsp_exc_reg   <= link.rsp_exc;
                        // Multi-item commands walk consecutive addresses
                        addr_reg      <= addr_reg + 16'h0001;
                        count_reg     <= count_reg - 8'h01;
                        state_reg     <= last ? ST_IDLE : ST_SEND;
                    end
                end
            endcase
        end
    end

    assign link.req_valid = req_valid_reg && i_ce;
    assign link.req_func  = func_reg;
    assign link.req_addr  = addr_reg;
    assign link.req_wdata = req_wdata_reg;
    assign o_rsp_valid    = rsp_valid_reg && i_ce;
    assign o_rsp_last     = rsp_last_reg;
    assign o_rsp_data     = rsp_data_reg;
    assign o_rsp_exc      = rsp_exc_reg;
    // Status bits unpacked from the read word: error, over, under
    assign o_rsp_flags = {rsp_data_reg[io_map_pkg::ST_ERROR_BIT],
                          rsp_data_reg[io_map_pkg::ST_OVER_BIT],
                          rsp_data_reg[io_map_pkg::ST_UNDER_BIT]};
endmodule // io_map_master
`default_nettype wire

// File: io_map_link_checker.sv
// Concurrent checks on the link between the master end and the coupler map
`default_nettype none
module io_map_link_checker (
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        i_ce,
    input wire logic        req_valid,
    input wire logic [7:0]  req_func,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic        rsp_valid,
    input wire logic [15:0] rsp_data,
    input wire logic [7:0]  rsp_exc
);
    // ****************************************************************
    // Request decode
    // ****************************************************************
    wire req_take = req_valid && i_ce;
    wire fn_known = req_func inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10};
    wire coil_fn  = req_func inside {8'h01, 8'h05, 8'h0f};
    wire ao_hit   = req_addr >= io_map_pkg::HR_AO_BASE
                 && req_addr < io_map_pkg::HR_AO_BASE + 16'h0004;
    wire st_hit   = req_addr == io_map_pkg::IR_AI_BASE || req_addr == io_map_pkg::IR_AI_BASE + 16'h0002;
    wire ctl_hit  = req_addr == io_map_pkg::HR_AO_BASE || req_addr == io_map_pkg::HR_AO_BASE + 16'h0002;
    wire bad_val  = req_wdata != io_map_pkg::COIL_ON && req_wdata != io_map_pkg::COIL_OFF;

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    // ****************************************************************
    // Properties
    // ****************************************************************
    a_answer_next: assert property (req_take |=> rsp_valid)
        else $error("link request got no answer one cycle later");
    a_answer_cause: assert property (rsp_valid |-> $past(req_take))
        else $error("link answer without a request");
    a_bad_function: assert property (req_take && !fn_known |=> rsp_exc == io_map_pkg::EXC_BAD_FUNC)
        else $error("unknown function not refused");
    a_coil_range: assert property (req_take && coil_fn && req_addr >= 16'(io_map_pkg::N_COIL)
        |=> rsp_exc == io_map_pkg::EXC_BAD_ADDR)
        else $error("coil address beyond range not refused");
    a_force_value: assert property (req_take && req_func == 8'h05 && req_addr < 16'h0004 && bad_val
        |=> rsp_exc == io_map_pkg::EXC_BAD_VALUE)
        else $error("bad single coil value not refused");
    a_ao_echo: assert property (req_take && req_func == 8'h06 && ao_hit
        |=> rsp_exc == io_map_pkg::EXC_NONE && rsp_data == $past(req_wdata))
        else $error("analog output write not accepted");
    a_bit_narrow: assert property (req_take && req_func inside {8'h01, 8'h02}
        |=> rsp_data[15:1] == 15'h0000)
        else $error("bit read answer wider than one bit");
    a_status_pad: assert property (req_take && req_func == 8'h04 && st_hit
        |=> (rsp_data & 16'hffbc) == 16'h0000)
        else $error("unassigned status bits not zero");
    a_ctrl_zero: assert property (req_take && req_func == 8'h03 && ctl_hit
        |=> rsp_data == 16'h0000)
        else $error("control word reads nonzero");
    a_packed_ro: assert property (req_take && req_func == 8'h06
        && req_addr == io_map_pkg::HR_COIL_WORD |=> rsp_exc == io_map_pkg::EXC_BAD_ADDR)
        else $error("packed relay word accepted a write");
    a_di_range: assert property (req_take && req_func == 8'h02 && req_addr >= 16'h0004
        |=> rsp_exc == io_map_pkg::EXC_BAD_ADDR)
        else $error("bit read of analog space not refused");
endmodule // io_map_link_checker
`default_nettype wire

// File: tb_modbus_io_register_map.sv
// Self-checking bench joining the master end and the coupler map
`default_nettype none
module tb_modbus_io_register_map;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_ref_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1;
    logic        i_cmd_valid = 1'b0, i_wdata_valid = 1'b0;
    logic [7:0]  i_cmd_func = 8'h00, i_cmd_count = 8'h00, rexc;
    logic [15:0] i_cmd_addr = 16'h0000, i_wdata = 16'h0000;
    logic [3:0]  i_di = 4'h0, coil_m, w;
    logic [1:0]  i_ai_error = 2'h0, i_ai_over = 2'h0, i_ai_under = 2'h0;
    logic [31:0] i_ai_value = 32'h0000_0000, ao_keep;
    logic        o_cmd_ready, o_wdata_ready, o_rsp_valid, o_rsp_last;
    logic [15:0] o_rsp_data, ad [4], wq [$], rd [$];
    logic [7:0]  o_rsp_exc;
    logic [2:0]  o_rsp_flags, rfl [$];
    logic [3:0]  o_coil_state;
    logic [31:0] o_ao_value;
    logic [7:0]  ef [6] = '{8'h06, 8'h05, 8'h02, 8'h01, 8'h07, 8'h06};
    logic [15:0] ea [6] = '{16'h0830, 16'h0000, 16'h0004, 16'h0004, 16'h0000, 16'h0800};
    logic [7:0]  ee [6] = '{8'h02, 8'h03, 8'h02, 8'h02, 8'h01, 8'h00};
    int          seed = 66033, bad_count = 0, n_compared = 0;

    always #4 i_ref_clk = ~i_ref_clk;

    io_map_link_if link ();
    io_map_coupler io_map_coupler_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce),
        .link(link), .i_di(i_di), .i_ai_error(i_ai_error), .i_ai_over(i_ai_over),
        .i_ai_under(i_ai_under), .i_ai_value(i_ai_value), .o_coil_state(o_coil_state),
        .o_ao_value(o_ao_value));
    io_map_master io_map_master_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce),
        .link(link), .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready),
        .i_cmd_func(i_cmd_func), .i_cmd_addr(i_cmd_addr), .i_cmd_count(i_cmd_count),
        .i_wdata_valid(i_wdata_valid), .o_wdata_ready(o_wdata_ready), .i_wdata(i_wdata),
        .o_rsp_valid(o_rsp_valid), .o_rsp_last(o_rsp_last), .o_rsp_data(o_rsp_data),
        .o_rsp_exc(o_rsp_exc), .o_rsp_flags(o_rsp_flags));
    io_map_link_checker io_map_link_checker_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_ce(i_ce), .req_valid(link.req_valid), .req_func(link.req_func),
        .req_addr(link.req_addr), .req_wdata(link.req_wdata), .rsp_valid(link.rsp_valid),
        .rsp_data(link.rsp_data), .rsp_exc(link.rsp_exc));

    // ****************************************************************
    // Write data feed, held until the design takes each word
    // ****************************************************************
    always @(negedge i_ref_clk) begin
        i_wdata_valid <= (wq.size() > 0);
        if (wq.size() > 0) i_wdata <= wq[0];
    end
    always @(posedge i_ref_clk) begin
        if (i_wdata_valid && o_wdata_ready) void'(wq.pop_front());
    end

    // ****************************************************************
    // Tasks and expectations
    // ****************************************************************
    function automatic logic [15:0] st(input int ch);
        return {9'h000, i_ai_error[ch], 4'h0, i_ai_over[ch], i_ai_under[ch]};
    endfunction

    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One command, response words gathered until the last flag
    task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [7:0] n);
        int k;
        rd.delete();
        rfl.delete();
        @(negedge i_ref_clk);
        {i_cmd_func, i_cmd_addr, i_cmd_count, i_cmd_valid} = {f, a, n, 1'b1};
        k = 0;
        while (o_cmd_ready !== 1'b1 && k < 50) begin
            @(negedge i_ref_clk);
            k++;
        end
        @(negedge i_ref_clk);
        i_cmd_valid = 1'b0;
        while (k < 200) begin
            if (o_rsp_valid === 1'b1) begin
                rd.push_back(o_rsp_data);
                rfl.push_back(o_rsp_flags);
                rexc = o_rsp_exc;
                if (o_rsp_last === 1'b1) k = 1000;
            end
            if (k < 1000) @(negedge i_ref_clk);
            k++;
        end
        if (k < 1000) begin
            bad_count++;
            $display("[ERR] command wait ran out");
            wrap_up();
        end
    endtask

    initial begin
        repeat (4) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_rst = 1'b0;
        // Inputs, analog status and values, first pass at full-scale corner
        for (int it = 0; it < 6; it++) begin
            @(negedge i_ref_clk);
            {i_di, i_ai_error, i_ai_over, i_ai_under} = 10'($random(seed));
            i_ai_value = (it == 0) ? 32'hffff_0000 : 32'($random(seed));
            xfer(8'h02, 16'h0000, 8'h04);
            for (int b = 0; b < 4; b++) chk("di_bit", rd[b], {15'h0000, i_di[b]});
            for (int j = 0; j < 2; j++) begin
                xfer(j ? 8'h03 : 8'h04, io_map_pkg::REG_DI_WORD, 8'h01);
                chk("di_word", rd[0], {12'h000, i_di});
                xfer(j ? 8'h03 : 8'h04, io_map_pkg::IR_AI_BASE, 8'h04);
                for (int c = 0; c < 2; c++) begin
                    chk("ai_status", rd[2 * c], st(c));
                    chk("ai_value", rd[2 * c + 1], i_ai_value[16 * c +: 16]);
                    chk("ai_flags", {13'h0000, rfl[2 * c]},
                        {13'h0000, i_ai_error[c], i_ai_over[c], i_ai_under[c]});
                end
            end
        end
        // Relay points, single forces then a block force
        coil_m = 4'h0;
        for (int it = 0; it < 4; it++) begin
            w = 4'($random(seed));
            wq.push_back(w[0] ? io_map_pkg::COIL_ON : io_map_pkg::COIL_OFF);
            xfer(8'h05, 16'(it), 8'h01);
            coil_m[it] = w[0];
            chk("coil_out", {12'h000, o_coil_state}, {12'h000, coil_m});
        end
        w = ~coil_m;
        for (int b = 0; b < 4; b++) wq.push_back({15'h0000, w[b]});
        xfer(8'h0f, 16'h0000, 8'h04);
        coil_m = w;
        xfer(8'h01, 16'h0000, 8'h04);
        for (int b = 0; b < 4; b++) chk("coil_bit", rd[b], {15'h0000, coil_m[b]});
        xfer(8'h03, io_map_pkg::HR_COIL_WORD, 8'h01);
        chk("coil_word", rd[0], {12'h000, coil_m});
        // Analog outputs: block write across control and data slots
        for (int b = 0; b < 4; b++) ad[b] = 16'($random(seed));
        for (int b = 0; b < 4; b++) wq.push_back(ad[b]);
        xfer(8'h10, io_map_pkg::HR_AO_BASE, 8'h04);
        chk("ao_out", o_ao_value[15:0], ad[1]);
        chk("ao_out", o_ao_value[31:16], ad[3]);
        wq.push_back(ad[0]);
        xfer(8'h06, io_map_pkg::HR_AO_BASE + 16'h0001, 8'h01);
        xfer(8'h03, io_map_pkg::HR_AO_BASE, 8'h04);
        chk("ao_ctrl", rd[0] | rd[2], 16'h0000);
        chk("ao_back", rd[1], ad[0]);
        chk("ao_back", rd[3], ad[3]);
        // Refusals leave state alone; control write is accepted quietly
        ao_keep = o_ao_value;
        for (int e = 0; e < 6; e++) begin
            if (ef[e] inside {8'h05, 8'h06}) wq.push_back(16'h1234);
            xfer(ef[e], ea[e], 8'h01);
            chk("exception", {8'h00, rexc}, {8'h00, ee[e]});
        end
        chk("coil_kept", {12'h000, o_coil_state}, {12'h000, coil_m});
        chk("ao_kept", o_ao_value[15:0], ao_keep[15:0]);
        chk("ao_kept", o_ao_value[31:16], ao_keep[31:16]);
        wrap_up();
    end
endmodule // tb_modbus_io_register_map
`default_nettype wire
